// >>> iapr_pkg.sv
// Package: constants and bus carriers for the interrupt acknowledge block
package iapr_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFS_REQ     = 8'h00;
  localparam logic [7:0]  OFS_MASK    = 8'h04;
  localparam logic [7:0]  OFS_LEVEL   = 8'h08;
  localparam logic [7:0]  OFS_STATUS  = 8'h0C;
  localparam logic [7:0]  OFS_SERVICE = 8'h10;

  // ----------------------------------------
  // Status word layout and reset values
  // ----------------------------------------
  localparam int unsigned ACCEPT_BIT  = 7;
  localparam int unsigned LEVEL_BIT   = 1;
  localparam logic [7:0]  STATUS_RST  = 8'h02;
  localparam logic        MASK_RST    = 1'b1;
  localparam logic        LEVEL_RST   = 1'b1;

  // ----------------------------------------
  // Vectors
  // ----------------------------------------
  localparam logic [15:0] TRAP_VEC    = 16'h003E;
  localparam logic [15:0] VEC_BASE    = 16'h0004;

  // ----------------------------------------
  // Timing, in CPU clocks
  // ----------------------------------------
  localparam int unsigned LAT_HI_MIN  = 7;
  localparam int unsigned LAT_LO_MIN  = 8;
  localparam int unsigned SEQ_TAIL    = 4;
  localparam logic [2:0]  WAIT_HI     = 3'(LAT_HI_MIN - SEQ_TAIL);
  localparam logic [2:0]  WAIT_LO     = 3'(LAT_LO_MIN - SEQ_TAIL);

  // ----------------------------------------
  // AXI4-Lite
  // ----------------------------------------
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } iapr_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } iapr_axi_rsp_type;

endpackage

// >>> iapr_top.sv
// Interrupt acknowledge, priority and nesting logic with AXI4-Lite registers
`timescale 1ns/1ns
module iapr_top #(
  parameter int unsigned N_SRC = 8
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  // Register bus
  input  wire iapr_pkg::iapr_axi_req_type axi_req,
  output      iapr_pkg::iapr_axi_rsp_type axi_rsp,
  // Peripheral request sources
  input  wire logic [N_SRC-1:0]          req_pulse,
  // CPU core sequencer
  input  wire logic                      instr_done,
  input  wire logic                      instr_defer,
  input  wire logic                      div_busy,
  input  wire logic                      software_trap_op,
  input  wire logic                      maskable_return_op,
  input  wire logic                      trap_return_op,
  input  wire logic [7:0]                restore_status,
  input  wire logic                      core_status_we,
  input  wire logic [7:0]                core_status_wdata,
  // Service sequence to the core
  output logic [7:0]                     status_word_reg,
  output logic [7:0]                     stack_status,
  output logic                           push_status,
  output logic                           push_counter,
  output logic                           vector_load,
  output logic [15:0]                    vector_addr
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    IAPR_IDLE, IAPR_WAIT, IAPR_PSH_ST, IAPR_PSH_PC, IAPR_VEC
  } iapr_state_type;

  iapr_state_type     state;
  logic [2:0]         wait_cnt;
  logic [N_SRC-1:0]   req_flag;
  logic [N_SRC-1:0]   request_mask_bit;
  logic [N_SRC-1:0]   level_select_bit;
  logic               bus_hold;
  logic               sel_trap;
  logic               sel_level;
  logic [7:0]         sel_src;
  logic               in_service;

  // Bus slave state
  logic               aw_got;
  logic               w_got;
  logic [7:0]         aw_addr;
  logic [7:0]         w_byte;
  logic               w_lane;
  logic [N_SRC-1:0]   sw_clr;
  logic [N_SRC-1:0]   sw_set;

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  logic [N_SRC-1:0]   acceptable;
  logic               any_hi;
  logic               any_lo;
  logic [7:0]         idx_hi;
  logic [7:0]         idx_lo;
  logic               global_accept_flag;
  logic               serviced_level_flag;
  logic               boundary;
  logic               take_mask;
  logic               take_trap;
  logic               grant_lvl;
  logic [7:0]         grant_idx;

  assign global_accept_flag  = status_word_reg[iapr_pkg::ACCEPT_BIT];
  assign serviced_level_flag = status_word_reg[iapr_pkg::LEVEL_BIT];
  assign acceptable          = req_flag & ~request_mask_bit;

  // Descending scan so the lowest index is left standing
  always_comb begin
    any_hi = 1'b0;
    any_lo = 1'b0;
    idx_hi = 8'h00;
    idx_lo = 8'h00;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (acceptable[i] && !level_select_bit[i]) begin
        any_hi = 1'b1;
        idx_hi = 8'(i);
      end
      if (acceptable[i] && level_select_bit[i]) begin
        any_lo = 1'b1;
        idx_lo = 8'(i);
      end
    end
  end

  // A boundary that follows a deferring instruction or register write
  // is skipped; a divide holds off the boundary altogether.
  assign boundary  = instr_done && !div_busy && !instr_defer && !bus_hold
                     && (state == IAPR_IDLE);
  assign take_trap = (state == IAPR_IDLE) && software_trap_op;
  assign take_mask = boundary && !software_trap_op && global_accept_flag
                     && (any_hi || (any_lo && serviced_level_flag));
  assign grant_lvl = !any_hi;
  assign grant_idx = any_hi ? idx_hi : idx_lo;

  // ----------------------------------------
  // Service sequence
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= IAPR_IDLE;
      wait_cnt  <= 3'h0;
      sel_trap  <= 1'b0;
      sel_level <= 1'b1;
      sel_src   <= 8'h00;
    end else begin
      case (state)
        IAPR_IDLE: begin
          if (take_trap) begin
            state    <= IAPR_WAIT;
            wait_cnt <= iapr_pkg::WAIT_HI;
            sel_trap <= 1'b1;
          end else if (take_mask) begin
            state     <= IAPR_WAIT;
            // Low level spends one more clock in the judge
            wait_cnt  <= grant_lvl ? iapr_pkg::WAIT_LO : iapr_pkg::WAIT_HI;
            sel_trap  <= 1'b0;
            sel_level <= grant_lvl;
            sel_src   <= grant_idx;
          end
        end
        IAPR_WAIT: begin
          if (wait_cnt <= 3'h1) begin
            state <= IAPR_PSH_ST;
          end
          wait_cnt <= wait_cnt - 3'h1;
        end
        IAPR_PSH_ST: state <= IAPR_PSH_PC;
        IAPR_PSH_PC: state <= IAPR_VEC;
        IAPR_VEC:    state <= IAPR_IDLE;
        default:     state <= IAPR_IDLE;
      endcase
    end
  end

  // Registered strobes to the core, one cycle each
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      push_status  <= 1'b0;
      push_counter <= 1'b0;
      vector_load  <= 1'b0;
      vector_addr  <= 16'h0000;
    end else begin
      push_status  <= (state == IAPR_WAIT) && (wait_cnt <= 3'h1);
      push_counter <= (state == IAPR_PSH_ST);
      vector_load  <= (state == IAPR_PSH_PC);
      if (state == IAPR_PSH_PC) begin
        vector_addr <= sel_trap ? iapr_pkg::TRAP_VEC
                     : iapr_pkg::VEC_BASE + {7'h00, sel_src, 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  // The value pushed is the one before acceptance altered it.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_word_reg <= iapr_pkg::STATUS_RST;
      stack_status    <= iapr_pkg::STATUS_RST;
    end else if (take_trap) begin
      stack_status <= status_word_reg;
      status_word_reg[iapr_pkg::ACCEPT_BIT] <= 1'b0;
    end else if (take_mask) begin
      stack_status <= status_word_reg;
      status_word_reg[iapr_pkg::ACCEPT_BIT] <= 1'b0;
      status_word_reg[iapr_pkg::LEVEL_BIT]  <= grant_lvl;
    end else if (maskable_return_op || trap_return_op) begin
      status_word_reg <= restore_status;
    end else if (core_status_we) begin
      status_word_reg <= core_status_wdata;
    end else if (aw_got && w_got && !axi_rsp.bvalid && w_lane
                 && aw_addr == iapr_pkg::OFS_STATUS) begin
      status_word_reg <= w_byte;
    end
  end

  // In-service marker, shown on the service register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_service <= 1'b0;
    end else if (take_trap || take_mask) begin
      in_service <= 1'b1;
    end else if (maskable_return_op || trap_return_op) begin
      in_service <= 1'b0;
    end
  end

  // ----------------------------------------
  // Request flags, masks and levels
  // ----------------------------------------
  logic bus_wr;

  assign bus_wr = aw_got && w_got && !axi_rsp.bvalid;

  always_comb begin
    sw_clr = '0;
    sw_set = '0;
    if (bus_wr && w_lane && aw_addr == iapr_pkg::OFS_REQ) begin
      sw_set = w_byte[N_SRC-1:0];
      sw_clr = ~w_byte[N_SRC-1:0];
    end
  end

  // Hardware set beats both software clear and acceptance clear
  generate
    for (genvar g = 0; g < N_SRC; g++) begin : gen_src
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          req_flag[g] <= 1'b0;
        end else if (req_pulse[g]) begin
          req_flag[g] <= 1'b1;
        end else if (take_mask && !grant_lvl == !level_select_bit[g]
                     && grant_idx == 8'(g)) begin
          req_flag[g] <= 1'b0;
        end else if (sw_set[g]) begin
          req_flag[g] <= 1'b1;
        end else if (sw_clr[g]) begin
          req_flag[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      request_mask_bit <= {N_SRC{iapr_pkg::MASK_RST}};
      level_select_bit <= {N_SRC{iapr_pkg::LEVEL_RST}};
    end else if (bus_wr && w_lane) begin
      if (aw_addr == iapr_pkg::OFS_MASK) begin
        request_mask_bit <= w_byte[N_SRC-1:0];
      end
      if (aw_addr == iapr_pkg::OFS_LEVEL) begin
        level_select_bit <= w_byte[N_SRC-1:0];
      end
    end
  end

  // A register write blocks the next instruction boundary only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_hold <= 1'b0;
    end else if (bus_wr && aw_addr < iapr_pkg::OFS_SERVICE) begin
      bus_hold <= 1'b1;
    end else if (instr_done && !div_busy) begin
      bus_hold <= 1'b0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  logic        wr_mapped;
  logic        aw_rdy;
  logic        w_rdy;
  logic        b_vld;
  logic [1:0]  b_resp;
  logic        ar_rdy;
  logic        r_vld;
  logic [31:0] r_data;
  logic [1:0]  r_resp;

  // One owner process per response field; the port gathers them in struct order
  assign axi_rsp = {aw_rdy, w_rdy, b_vld, b_resp, ar_rdy, r_vld, r_data, r_resp};

  assign wr_mapped = aw_addr <= iapr_pkg::OFS_STATUS && aw_addr[1:0] == 2'h0;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= 8'h00;
      w_byte  <= 8'h00;
      w_lane  <= 1'b0;
      aw_rdy  <= 1'b1;
      w_rdy   <= 1'b1;
      b_vld   <= 1'b0;
      b_resp  <= iapr_pkg::RESP_OKAY;
    end else begin
      if (axi_req.awvalid && aw_rdy) begin
        aw_got  <= 1'b1;
        aw_addr <= axi_req.awaddr;
        aw_rdy  <= 1'b0;
      end
      if (axi_req.wvalid && w_rdy) begin
        w_got  <= 1'b1;
        w_byte <= axi_req.wdata[7:0];
        w_lane <= axi_req.wstrb[0];
        w_rdy  <= 1'b0;
      end
      if (bus_wr) begin
        b_vld  <= 1'b1;
        b_resp <= wr_mapped ? iapr_pkg::RESP_OKAY : iapr_pkg::RESP_SLVERR;
      end
      if (b_vld && axi_req.bready) begin
        b_vld  <= 1'b0;
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        aw_rdy <= 1'b1;
        w_rdy  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  logic [31:0] rd_word;
  logic        rd_ok;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (axi_req.araddr)
      iapr_pkg::OFS_REQ:     rd_word[N_SRC-1:0] = req_flag;
      iapr_pkg::OFS_MASK:    rd_word[N_SRC-1:0] = request_mask_bit;
      iapr_pkg::OFS_LEVEL:   rd_word[N_SRC-1:0] = level_select_bit;
      iapr_pkg::OFS_STATUS:  rd_word[7:0]       = status_word_reg;
      iapr_pkg::OFS_SERVICE: rd_word[15:0]      = {sel_src, in_service,
                                                   (state != IAPR_IDLE),
                                                   sel_trap, sel_level, 4'h0};
      default:               rd_ok              = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ar_rdy <= 1'b1;
      r_vld  <= 1'b0;
      r_data <= 32'h0000_0000;
      r_resp <= iapr_pkg::RESP_OKAY;
    end else if (axi_req.arvalid && ar_rdy) begin
      ar_rdy <= 1'b0;
      r_vld  <= 1'b1;
      r_data <= rd_word;
      r_resp <= rd_ok ? iapr_pkg::RESP_OKAY : iapr_pkg::RESP_SLVERR;
    end else if (r_vld && axi_req.rready) begin
      r_vld  <= 1'b0;
      ar_rdy <= 1'b1;
    end
  end

endmodule

// >>> iapr_monitor.sv
// Checker for the acknowledge sequence seen at the top ports
`timescale 1ns/1ns
module iapr_monitor #(
  parameter int unsigned N_SRC = 8
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        arst_n,
  // Core side
  input wire logic        software_trap_op,
  input wire logic [7:0]  status_word_reg,
  input wire logic [7:0]  stack_status,
  input wire logic        push_status,
  input wire logic        push_counter,
  input wire logic        vector_load,
  input wire logic [15:0] vector_addr
);
  // ----
  // Properties
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_order;
    push_status |=> push_counter ##1 vector_load;
  endproperty
  a_order: assert property (p_order) else $error("push order broken");
  property p_pulse;
    push_status |=> !push_status;
  endproperty
  a_pulse: assert property (p_pulse) else $error("push longer than one cycle");
  property p_trap_seq;
    software_trap_op |-> ##4 push_status ##2 vector_load && vector_addr == iapr_pkg::TRAP_VEC;
  endproperty
  a_trap_seq: assert property (p_trap_seq) else $error("trap not vectored");
  property p_trap_clr;
    software_trap_op |=> !status_word_reg[7];
  endproperty
  a_trap_clr: assert property (p_trap_clr) else $error("trap left accept set");
  property p_vec;
    vector_load |-> vector_addr == iapr_pkg::TRAP_VEC || (!vector_addr[0] &&
      vector_addr >= iapr_pkg::VEC_BASE && vector_addr < iapr_pkg::VEC_BASE + 16'(2 * N_SRC));
  endproperty
  a_vec: assert property (p_vec) else $error("vector outside table");
  property p_hold;
    vector_load |=> $stable(vector_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("vector not held");
  property p_rst;
    $rose(arst_n) |-> status_word_reg == iapr_pkg::STATUS_RST
      && stack_status == iapr_pkg::STATUS_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("status not at reset value");
  property p_acc_clr;
    push_status |-> !status_word_reg[7];
  endproperty
  a_acc_clr: assert property (p_acc_clr) else $error("accept still set in service");
endmodule
bind iapr_top iapr_monitor #(.N_SRC(N_SRC)) u_mon (
  .core_clk(core_clk), .arst_n(arst_n), .software_trap_op(software_trap_op),
  .status_word_reg(status_word_reg), .stack_status(stack_status), .push_status(push_status),
  .push_counter(push_counter), .vector_load(vector_load), .vector_addr(vector_addr)
);

// >>> iapr_core_model.sv
// Core sequencer model giving instruction boundaries
`timescale 1ns/1ns
module iapr_core_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Pace and boundary
  input  wire logic slow,
  output logic      instr_done
);
  logic [2:0] cnt;
  // Slow mode stands for long instructions, stretching latency
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 3'h0;
      instr_done <= 1'b0;
    end else if (cnt >= (slow ? 3'h4 : 3'h1)) begin
      cnt <= 3'h0;
      instr_done <= 1'b1;
    end else begin
      cnt <= cnt + 3'h1;
      instr_done <= 1'b0;
    end
  end
endmodule

// >>> iapr_tb_top.sv
// Self-checking bench for the interrupt acknowledge block
`timescale 1ns/1ns
module iapr_tb_top;
  localparam logic [7:0]  MSK = iapr_pkg::OFS_MASK;
  localparam logic [7:0]  LVL = iapr_pkg::OFS_LEVEL;
  localparam logic [15:0] VB  = iapr_pkg::VEC_BASE;
  iapr_pkg::iapr_axi_req_type axi_req;
  iapr_pkg::iapr_axi_rsp_type axi_rsp;
  logic        core_clk, arst_n, instr_done, instr_defer, div_busy, slow;
  logic        software_trap_op, maskable_return_op, trap_return_op, core_status_we;
  logic        push_status, push_counter, vector_load;
  logic [7:0]  req_pulse, restore_status, core_status_wdata, status_word_reg, stack_status;
  logic [15:0] vector_addr;
  logic [1:0]  bresp_seen;
  int          errors, check_count, n;
  iapr_top #(.N_SRC(8)) uut (
    .core_clk, .arst_n, .axi_req, .axi_rsp, .req_pulse, .instr_done, .instr_defer,
    .div_busy, .software_trap_op, .maskable_return_op, .trap_return_op, .restore_status,
    .core_status_we, .core_status_wdata, .status_word_reg, .stack_status, .push_status,
    .push_counter, .vector_load, .vector_addr
  );
  iapr_core_model u_core (.core_clk, .arst_n, .slow, .instr_done);
  // ----
  // Helpers
  // ----
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    axi_req.awaddr <= a;
    axi_req.wdata <= {24'h00_0000, d};
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!axi_rsp.bvalid);
    bresp_seen = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    @(posedge core_clk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (!axi_rsp.rvalid);
    chk(nm, axi_rsp.rdata, e);
    chk("resp", 32'(axi_rsp.rresp), 32'(er));
    axi_req.rready <= 1'b0;
  endtask
  task automatic cw(input logic [7:0] v);
    @(posedge core_clk);
    core_status_wdata <= v;
    core_status_we <= 1'b1;
    @(posedge core_clk);
    core_status_we <= 1'b0;
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge core_clk);
    req_pulse <= m;
    @(posedge core_clk);
    req_pulse <= 8'h00;
  endtask
  // Cycles until a vector load, 99 when none comes
  task automatic wv;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!vector_load && n < 60);
    if (!vector_load) n = 99;
  endtask
  // Return is a deferring instruction, so its boundary carries the defer flag
  task automatic ret(input logic trp, input logic [7:0] v);
    @(posedge core_clk);
    restore_status <= v;
    trap_return_op <= trp;
    maskable_return_op <= !trp;
    instr_defer <= 1'b1;
    @(posedge core_clk);
    trap_return_op <= 1'b0;
    maskable_return_op <= 1'b0;
    do @(posedge core_clk); while (!instr_done);
    instr_defer <= 1'b0;
  endtask
  task automatic rst;
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic s_reset;
    chk("status", 32'(status_word_reg), 32'h0000_0002);
    rdc("st", iapr_pkg::OFS_STATUS, 32'h0000_0002, iapr_pkg::RESP_OKAY);
    rdc("mask", MSK, 32'h0000_00FF, iapr_pkg::RESP_OKAY);
    rdc("lvl", LVL, 32'h0000_00FF, iapr_pkg::RESP_OKAY);
    rdc("req", iapr_pkg::OFS_REQ, 32'h0000_0000, iapr_pkg::RESP_OKAY);
    rdc("hole", 8'h14, 32'h0000_0000, iapr_pkg::RESP_SLVERR);
  endtask
  task automatic s_basic;
    for (int lv = 0; lv < 2; lv++) begin
      rst();
      slow <= lv[0];
      wr(MSK, 8'hF7);
      wr(LVL, lv[0] ? 8'hFF : 8'hF7);
      cw(8'h82);
      pulse(8'h08);
      wv();
      chk("lat", 32'(n >= 7 + lv && n <= 32 + lv), 1);
      chk("vec", 32'(vector_addr), 32'(VB + 16'h0006));
      chk("st", 32'(status_word_reg), {30'h0, lv[0], 1'b0});
      chk("stk", 32'(stack_status), 32'h0000_0082);
    end
    slow <= 1'b0;
  endtask
  task automatic s_prio;
    rst();
    wr(MSK, 8'h00);
    wr(LVL, 8'hBF);
    cw(8'h82);
    pulse(8'h44);
    wv();
    chk("hi", 32'(vector_addr), 32'(VB + 16'h000C));
    rdc("req", iapr_pkg::OFS_REQ, 32'h0000_0004, iapr_pkg::RESP_OKAY);
    rdc("svc", iapr_pkg::OFS_SERVICE, 32'h0000_0680, iapr_pkg::RESP_OKAY);
    ret(1'b0, 8'h82);
    wv();
    chk("pend", 32'(vector_addr), 32'(VB + 16'h0004));
    chk("st", 32'(status_word_reg), 32'h0000_0002);
    rst();
    wr(MSK, 8'h00);
    wr(LVL, 8'h00);
    cw(8'h82);
    pulse(8'h12);
    wv();
    chk("tie", 32'(vector_addr), 32'(VB + 16'h0002));
  endtask
  task automatic s_mask;
    rst();
    wr(LVL, 8'h00);
    wr(MSK, 8'hFE);
    cw(8'h82);
    pulse(8'h02);
    wv();
    chk("masked", n, 99);
    cw(8'h02);
    pulse(8'h01);
    wv();
    chk("off", n, 99);
    wr(MSK, 8'hFC);
    cw(8'h82);
    wv();
    chk("late", 32'(vector_addr), 32'(VB));
  endtask
  task automatic s_nest;
    rst();
    wr(MSK, 8'hF8);
    wr(LVL, 8'hFA);
    cw(8'h82);
    pulse(8'h01);
    wv();
    chk("st", 32'(status_word_reg), 32'h0000_0000);
    cw(8'h80);
    pulse(8'h02);
    wv();
    chk("low", n, 99);
    pulse(8'h04);
    wv();
    chk("nest", 32'(vector_addr), 32'(VB + 16'h0004));
    chk("stk", 32'(stack_status), 32'h0000_0080);
    ret(1'b0, 8'h80);
    chk("ret", 32'(status_word_reg), 32'h0000_0080);
    wv();
    chk("still", n, 99);
    ret(1'b0, 8'h82);
    wv();
    chk("pend", 32'(vector_addr), 32'(VB + 16'h0002));
  endtask
  task automatic s_trap;
    rst();
    cw(8'h82);
    @(posedge core_clk);
    software_trap_op <= 1'b1;
    @(posedge core_clk);
    software_trap_op <= 1'b0;
    wv();
    chk("trap", 32'(vector_addr), 32'(iapr_pkg::TRAP_VEC));
    chk("st", 32'(status_word_reg), 32'h0000_0002);
    chk("stk", 32'(stack_status), 32'h0000_0082);
    rdc("svc", iapr_pkg::OFS_SERVICE, 32'h0000_00B0, iapr_pkg::RESP_OKAY);
    wr(MSK, 8'hFE);
    wr(LVL, 8'hFE);
    pulse(8'h01);
    wv();
    chk("off", n, 99);
    cw(8'h82);
    wv();
    chk("nest", 32'(vector_addr), 32'(VB));
    ret(1'b1, 8'h02);
    chk("ret", 32'(status_word_reg), 32'h0000_0002);
  endtask
  task automatic s_hold;
    for (int k = 0; k < 2; k++) begin
      rst();
      wr(MSK, 8'hFE);
      wr(LVL, 8'hFE);
      cw(8'h82);
      div_busy <= k[0];
      instr_defer <= !k[0];
      pulse(8'h01);
      wv();
      chk("held", n, 99);
      div_busy <= 1'b0;
      instr_defer <= 1'b0;
      wv();
      chk("go", 32'(vector_addr), 32'(VB));
    end
  endtask
  task automatic s_regs;
    rst();
    wr(iapr_pkg::OFS_STATUS, 8'h82);
    chk("bresp", 32'(bresp_seen), 32'(iapr_pkg::RESP_OKAY));
    rdc("st", iapr_pkg::OFS_STATUS, 32'h0000_0082, iapr_pkg::RESP_OKAY);
    axi_req.wstrb <= 4'h0;
    wr(iapr_pkg::OFS_REQ, 8'h05);
    axi_req.wstrb <= 4'hF;
    rdc("lane", iapr_pkg::OFS_REQ, 32'h0000_0000, iapr_pkg::RESP_OKAY);
    wr(iapr_pkg::OFS_REQ, 8'h05);
    rdc("sw", iapr_pkg::OFS_REQ, 32'h0000_0005, iapr_pkg::RESP_OKAY);
    wr(MSK, 8'hFE);
    wv();
    chk("vec", 32'(vector_addr), 32'(VB));
    chk("st", 32'(status_word_reg), 32'h0000_0002);
    rdc("req", iapr_pkg::OFS_REQ, 32'h0000_0004, iapr_pkg::RESP_OKAY);
    wr(iapr_pkg::OFS_REQ, 8'h00);
    rdc("clr", iapr_pkg::OFS_REQ, 32'h0000_0000, iapr_pkg::RESP_OKAY);
    wr(8'h14, 8'hFF);
    chk("hole", 32'(bresp_seen), 32'(iapr_pkg::RESP_SLVERR));
    chk("kept", 32'(status_word_reg), 32'h0000_0002);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #200_000;
    errors++;
    complete_run();
  end
  initial begin
    {arst_n, instr_defer, div_busy, slow, core_status_we} = 5'h00;
    {software_trap_op, maskable_return_op, trap_return_op} = 3'h0;
    {req_pulse, restore_status, core_status_wdata} = 24'h00_0000;
    axi_req = '0;
    axi_req.wstrb = 4'hF;
    errors = 0;
    check_count = 0;
    rst();
    s_reset();
    s_basic();
    s_prio();
    s_mask();
    s_nest();
    s_trap();
    s_hold();
    s_regs();
    complete_run();
  end
endmodule
